// [dv/fps_chk.sv]
module fps_chk
  import fps_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 srst,
  // request and answer
  input wire logic                 req_valid,
  input wire logic                 req_write,
  input wire fps_src_t             req_src,
  input wire logic                 grant,
  input wire logic                 reject,
  // security state
  input wire logic                 secured,
  input wire logic                 debug_on,
  input wire logic                 test_on,
  input wire logic [FPS_KEY_W-1:0] swd_latch_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_read(s);
    req_valid && !req_write && req_src == s;
  endsequence
  chk_one_answer: assert property (req_valid |=> grant ^ reject)
    else $error("one answer expected");
  chk_no_spur: assert property (!req_valid |=> !grant && !reject)
    else $error("answer without request");
  chk_int_read: assert property (s_read(FPS_SRC_INTERNAL) |=> grant)
    else $error("internal read refused");
  chk_boot_read: assert property (s_read(FPS_SRC_BOOTLOADER) |=> grant)
    else $error("boot read refused");
  chk_sec_ext: assert property (req_valid && secured && req_src == FPS_SRC_EXTERNAL |=> reject)
    else $error("external access while secured");
  chk_sec_modes: assert property (secured |-> !debug_on && !test_on)
    else $error("mode entered while secured");
  chk_latch_key: assert property (secured && $past(secured) |-> swd_latch_rd == FPS_SEC_KEY)
    else $error("latch read differs");
  chk_sec_hold: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(secured))
    else $error("security changed without reset");
endmodule : fps_chk

bind fps_top fps_chk i_chk (.*);

// [dv/fps_probe.sv]
module fps_probe (
  // wishes from the bench
  input  wire logic want_dbg,
  input  wire logic want_test,
  // pins towards the device
  output logic      debug_req_pin,
  output logic      test_req_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move unrelated to the device clock
  assign #3 debug_req_pin = want_dbg;
  assign #3 test_req_pin = want_test;
endmodule : fps_probe

// [dv/tb_flash_protection_security.sv]
module tb_flash_protection_security;
  import fps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, srst = 1, req_valid = 0, req_write = 0, prot_wr = 0, erase_all = 0;
  logic key_wr = 0, want_dbg = 0, want_test = 0, bscan_pin = 0, grant, reject, secured;
  logic debug_on, test_on, debug_req_pin, test_req_pin, sec_exp = 0, dbg_exp = 0;
  fps_src_t             req_src = FPS_SRC_INTERNAL;
  fps_prot_t            prot_val = FPS_PROT_NONE;
  fps_prot_t            mode [4] = '{default: FPS_PROT_NONE};
  logic [FPS_ROW_W-1:0] req_row = '0, prot_row = '0;
  logic [FPS_KEY_W-1:0] key_data = '0, swd_latch_rd;
  logic [31:0]          seed = 32'h0000_0057;
  logic                 q [$];
  int                   fails = 0, n_checks = 0;
  always #10 sys_clk = ~sys_clk;
  fps_top i_dut (.*);
  fps_probe i_probe (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic allow(fps_src_t s, logic w, fps_prot_t m);
    if (s == FPS_SRC_INTERNAL || s == FPS_SRC_BOOTLOADER)
      return w ? m != FPS_PROT_FULL : 1'b1;
    if (sec_exp)
      return 1'b0;
    if (!w && s == FPS_SRC_DEBUG && dbg_exp)
      return 1'b1;
    return w ? m inside {FPS_PROT_NONE, FPS_PROT_EXT_READ} : m inside {0, 2};
  endfunction : allow
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic req(fps_src_t s, logic w, logic [1:0] r);
    @(negedge sys_clk);
    req_valid = 1;
    req_src = s;
    req_write = w;
    req_row = 8'(r);
    q.push_back(allow(s, w, mode[r]));
  endtask : req
  task automatic idle(int n);
    @(negedge sys_clk);
    {req_valid, prot_wr, erase_all, key_wr} = '0;
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic rst();
    idle(0);
    srst = 1;
    idle(1);
    srst = 0;
  endtask : rst
  task automatic sweep();
    for (int k = 0; k < 32; k++) req(fps_src_t'(k[4:3]), k[2], k[1:0]);
    idle(1);
  endtask : sweep
  always @(negedge sys_clk) begin
    if (grant || reject) begin
      check(q.size() != 0, 1, "pending");
      check({grant, reject}, {q[0], !q[0]}, "answer");
      void'(q.pop_front());
    end
  end
  initial begin
    logic [31:0] r;
    repeat (12) @(negedge sys_clk);
    srst = 0;
    erase_all = 1;
    for (int i = 0; i < 4; i++) begin
      idle(0);
      {prot_wr, prot_row, prot_val} = {1'b1, 8'(i), fps_prot_t'(i)};
    end
    req(FPS_SRC_EXTERNAL, 1, 3);
    rst();
    mode = '{FPS_PROT_NONE, FPS_PROT_EXT_READ, FPS_PROT_EXT_WRITE, FPS_PROT_FULL};
    {prot_wr, prot_row, prot_val} = {1'b1, 8'h03, FPS_PROT_NONE};
    rst();
    sweep();
    repeat (16) begin
      r = xs();
      req(fps_src_t'(r[1:0]), r[2], r[4:3]);
    end
    want_dbg = 1;
    want_test = 1;
    idle(6);
    dbg_exp = 1;
    check(debug_on, 1, "debug_on");
    check(test_on, 1, "test_on");
    for (int k = 0; k < 8; k++) req(FPS_SRC_DEBUG, k[2], k[1:0]);
    bscan_pin = 1;
    idle(6);
    dbg_exp = 0;
    req(FPS_SRC_DEBUG, 0, 3);
    {bscan_pin, key_wr, key_data} = {2'b01, FPS_SEC_KEY};
    idle(0);
    {key_wr, key_data} = {1'b1, ~FPS_SEC_KEY};
    idle(2);
    check(swd_latch_rd, FPS_SEC_KEY, "latch");
    check(secured, 0, "secured early");
    rst();
    sec_exp = 1;
    erase_all = 1;
    idle(6);
    check(secured, 1, "secured");
    check({debug_on, test_on}, 0, "modes");
    sweep();
    idle(3);
    check(q.size(), 0, "queue");
    give_verdict();
  end
  initial begin
    #50us;
    fails++;
    give_verdict();
  end
endmodule : tb_flash_protection_security

// [pkg/fps_dec_if.sv]
interface fps_dec_if;
  import fps_pkg::*;
  fps_prot_t prot;
  fps_src_t  src;
  logic      is_write;
  logic      secured;
  logic      debug_on;
  logic      allow;
  modport req (output prot, output src, output is_write, output secured,
               output debug_on, input allow);
  modport dec (input prot, input src, input is_write, input secured,
               input debug_on, output allow);
endinterface : fps_dec_if

// [pkg/fps_pkg.sv]
package fps_pkg;

  // row protection modes
  typedef enum logic [1:0] {
    FPS_PROT_NONE      = 2'h0,
    FPS_PROT_EXT_READ  = 2'h1,
    FPS_PROT_EXT_WRITE = 2'h2,
    FPS_PROT_FULL      = 2'h3
  } fps_prot_t;

  // request sources
  typedef enum logic [1:0] {
    FPS_SRC_INTERNAL   = 2'h0,
    FPS_SRC_BOOTLOADER = 2'h1,
    FPS_SRC_EXTERNAL   = 2'h2,
    FPS_SRC_DEBUG      = 2'h3
  } fps_src_t;

  localparam int unsigned FPS_ROW_W   = 8;
  localparam int unsigned FPS_NROWS   = 256;
  localparam int unsigned FPS_KEY_W   = 32;
  localparam int unsigned FPS_SYNC_N  = 3;

  // security key value is arbitrary
  localparam logic [31:0] FPS_SEC_KEY = 32'h5EC0_0001;
  localparam logic [31:0] FPS_KEY_RST = 32'h0000_0000;

endpackage : fps_pkg

// [rtl/fps_decide.sv]
module fps_decide
  import fps_pkg::*;
(
  fps_dec_if.dec d
);

  always_comb begin
    d.allow = 1'b0;
    if (!d.is_write) begin
      case (d.src)
        FPS_SRC_INTERNAL:   d.allow = 1'b1;
        FPS_SRC_BOOTLOADER: d.allow = 1'b1;
        FPS_SRC_DEBUG:      d.allow = !d.secured;
        FPS_SRC_EXTERNAL:   d.allow = !d.secured && (d.prot == FPS_PROT_NONE ||
                                       d.prot == FPS_PROT_EXT_WRITE);
        default:            d.allow = 1'b0;
      endcase
    end else begin
      case (d.src)
        FPS_SRC_INTERNAL,
        FPS_SRC_BOOTLOADER: d.allow = (d.prot != FPS_PROT_FULL);
        FPS_SRC_DEBUG,
        FPS_SRC_EXTERNAL:   d.allow = !d.secured && (d.prot == FPS_PROT_NONE ||
                                       d.prot == FPS_PROT_EXT_READ);
        default:            d.allow = 1'b0;
      endcase
    end
  end

endmodule : fps_decide

// [rtl/fps_top.sv]
// What this block does
// - row protection changes only through a whole-array erase followed by reprogramming.
// - reads by internal code are allowed in every protection mode.
// - in debug mode, except during boundary scan, the read-protection part of a row setting is ignored.
// - in debug mode write protection holds and fully protected rows are never written.
// - bootloader code may write rows that block external writes.
// - a 32-bit key in the write-once latch enables security and bars debug and test entry.
// - once secured, test-mode reprogramming and debug entry during boundary scan are refused.
// - the write-once latch is readable through the serial debug port.
// - when secured all external flash reads and writes are blocked.
// - when secured bootloader writes still pass except to fully protected rows.
// - key and protection settings take effect only after a device reset.
module fps_top
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // flash access request
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire fps_src_t             req_src,
  input  wire logic [FPS_ROW_W-1:0] req_row,
  output logic                      grant,
  output logic                      reject,
  // protection configuration
  input  wire logic                 prot_wr,
  input  wire logic [FPS_ROW_W-1:0] prot_row,
  input  wire fps_prot_t            prot_val,
  input  wire logic                 erase_all,
  // write-once latch
  input  wire logic                 key_wr,
  input  wire logic [FPS_KEY_W-1:0] key_data,
  output logic [FPS_KEY_W-1:0]      swd_latch_rd,
  output logic                      secured,
  // mode entry requests from pins
  input  wire logic                 debug_req_pin,
  input  wire logic                 test_req_pin,
  input  wire logic                 bscan_pin,
  output logic                      debug_on,
  output logic                      test_on
);

  fps_prot_t             row_pend [FPS_NROWS];
  fps_prot_t             next_row_pend [FPS_NROWS];
  fps_prot_t             row_act [FPS_NROWS];
  logic                  next_grant;
  logic                  next_reject;
  logic [FPS_KEY_W-1:0]  latch;
  logic [FPS_KEY_W-1:0]  next_latch;
  logic                  latch_set;
  logic                  next_latch_set;
  logic                  sec_act;
  logic                  next_sec_act;
  logic                  loaded = 1'b0;
  logic [FPS_SYNC_N-1:0] dbg_s;
  logic [FPS_SYNC_N-1:0] tst_s;
  logic [FPS_SYNC_N-1:0] bsc_s;
  logic                  dbg_q;
  logic                  tst_q;
  logic                  bsc_q;
  logic                  next_dbg_q;
  logic                  next_tst_q;
  logic                  next_bsc_q;
  logic                  next_debug_on;
  logic                  next_test_on;
  logic                  row_erased [FPS_NROWS];
  logic                  next_row_erased [FPS_NROWS];

  fps_dec_if dif ();

  function automatic logic filt(input logic [FPS_SYNC_N-1:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction : filt

  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dbg_s <= '0;
      tst_s <= '0;
      bsc_s <= '0;
    end else begin
      dbg_s <= {dbg_s[1:0], debug_req_pin};
      tst_s <= {tst_s[1:0], test_req_pin};
      bsc_s <= {bsc_s[1:0], bscan_pin};
    end
  end

  always_comb begin
    next_dbg_q    = filt(dbg_s, dbg_q);
    next_tst_q    = filt(tst_s, tst_q);
    next_bsc_q    = filt(bsc_s, bsc_q);
    next_debug_on = next_dbg_q && !sec_act;
    next_test_on  = next_tst_q && !sec_act;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dbg_q    <= 1'b0;
      tst_q    <= 1'b0;
      bsc_q    <= 1'b0;
      debug_on <= 1'b0;
      test_on  <= 1'b0;
    end else begin
      dbg_q    <= next_dbg_q;
      tst_q    <= next_tst_q;
      bsc_q    <= next_bsc_q;
      debug_on <= next_debug_on;
      test_on  <= next_test_on;
    end
  end

  // write-once latch, contents survive srst; active copy taken at reset
  always_comb begin
    next_latch     = latch;
    next_latch_set = latch_set;
    if (key_wr && !latch_set) begin
      next_latch     = key_data;
      next_latch_set = 1'b1;
    end
    next_sec_act = sec_act;
  end

  always_ff @(posedge sys_clk) begin
    if (!loaded) begin
      latch     <= FPS_KEY_RST;
      latch_set <= 1'b0;
      loaded    <= 1'b1;
    end else begin
      latch     <= next_latch;
      latch_set <= next_latch_set;
    end
    if (srst) begin
      sec_act <= (latch == FPS_SEC_KEY);
    end else begin
      sec_act <= next_sec_act;
    end
  end

  // row protection store: pending settings become active at reset
  always_comb begin
    for (int i = 0; i < FPS_NROWS; i++) begin
      next_row_pend[i]   = row_pend[i];
      next_row_erased[i] = row_erased[i];
      if (erase_all && !sec_act) begin
        next_row_erased[i] = 1'b1;
      end
    end
    if (prot_wr && row_erased[prot_row] && !erase_all) begin
      next_row_pend[prot_row]   = prot_val;
      next_row_erased[prot_row] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < FPS_NROWS; i++) begin
      if (!loaded) begin
        row_pend[i]   <= FPS_PROT_NONE;
        row_erased[i] <= 1'b1;
      end else begin
        row_pend[i]   <= next_row_pend[i];
        row_erased[i] <= next_row_erased[i];
      end
      if (srst) begin
        row_act[i] <= row_pend[i];
      end
    end
  end

  // access decision
  assign dif.prot     = row_act[req_row];
  assign dif.src      = (req_src == FPS_SRC_DEBUG && !(debug_on && !bsc_q))
                        ? FPS_SRC_EXTERNAL : req_src;
  assign dif.is_write = req_write;
  assign dif.secured  = sec_act;
  assign dif.debug_on = debug_on;

  fps_decide u_decide (
    .d (dif.dec)
  );

  always_comb begin
    next_grant  = req_valid && dif.allow;
    next_reject = req_valid && !dif.allow;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      grant        <= 1'b0;
      reject       <= 1'b0;
      swd_latch_rd <= FPS_KEY_RST;
      secured      <= 1'b0;
    end else begin
      grant        <= next_grant;
      reject       <= next_reject;
      swd_latch_rd <= latch;
      secured      <= sec_act;
    end
  end

endmodule : fps_top
